// file: logic/cdgo_regs.svh
// Register map, field positions, reset values and numeric constants for the
// per-lane digital gain and offset correction block.
// Assumes a 16-bit register port addressed by register index.
//
// Operation
// R1: Lane gain code acts only while the amplify correction enable is 1.
// R2: Gain field bits 15..11 is unsigned N giving N times 0.2 dB.
// R3: Lane offset is added only while the dc shift correction enable is 1.
// R4: Offset field bits 9..0 is a 10-bit two's-complement value.
// R5: One offset unit equals one LSB of the 14-bit sample word.
// R6: Software writes the same offset into both registers of a lane pair.
// R7: Lane 2 pair at 0x0f and 0x10, lane 3 pair at 0x11 and 0x12.
// R8: Lane 1 offset mirror at 0x0e, offset bits 9..0, bits 15..10 unused.
// R9: All bits read and write, and reset to zero.
// R10: Lane 1 gain and offset register at 0x0d, same layout as others.
// R11: With both corrections on, apply offset and gain, saturate to range.
`ifndef CDGO_REGS_SVH
`define CDGO_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets (register index on the port)
// ----------------------------------------------------------------------------
`define CDGO_CH1_GAIN_AND_SHIFT 8'h0d
`define CDGO_CH1_OFFSET_MIRROR 8'h0e
`define CDGO_CH2_GAIN_AND_SHIFT 8'h0f
`define CDGO_CH2_OFFSET_MIRROR 8'h10
`define CDGO_CH3_GAIN_AND_SHIFT 8'h11
`define CDGO_CH3_OFFSET_MIRROR 8'h12
`define CDGO_CTRL 8'h20

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define CDGO_GAIN_MSB 15
`define CDGO_GAIN_LSB 11
`define CDGO_OFS_MSB 9
`define CDGO_OFS_LSB 0
`define CDGO_CTRL_GAIN_EN_BIT 0
`define CDGO_CTRL_OFS_EN_BIT 1
`define CDGO_REG_RESET 16'h0000

// ----------------------------------------------------------------------------
// Gain table: 0.2 dB per code step, linear factor in Q2.14
// ----------------------------------------------------------------------------
`define CDGO_GAIN_FRAC 14

`endif

// file: logic/cdgo_pkg.sv
// Types shared by the gain and offset correction block.
// Assumes the constants header is included by each user.
package cdgo_pkg;
  typedef logic [4:0] cdgo_gain_t;
  typedef logic signed [9:0] cdgo_ofs_t;
  typedef logic [15:0] cdgo_word_t;
  typedef enum logic [1:0] {
    cdgo_pass,
    cdgo_gain_only,
    cdgo_ofs_only,
    cdgo_both
  } cdgo_mode_e;
endpackage

// file: logic/cdgo_gain_lut.sv
// Lookup of the linear multiplier for a gain code in 0.2 dB steps.
// Assumes a purely combinational use inside the lane datapath.
`timescale 1ns/1ns
`include "cdgo_regs.svh"
module cdgo_gain_lut
  import cdgo_pkg::*;
(
  // Code in and factor out.
  input wire cdgo_gain_t code,
  output logic [17:0] factor
);

  // -------------------------------------------------------------------------
  // Factor is round(2^14 * 10^(N*0.2/20)); kept as constants, not a file.
  // -------------------------------------------------------------------------
  always_comb begin
    case (code) // R2
      5'h00: factor = 18'h04000;
      5'h01: factor = 18'h0417e;
      5'h02: factor = 18'h04304;
      5'h03: factor = 18'h04494;
      5'h04: factor = 18'h0462d;
      5'h05: factor = 18'h047cf;
      5'h06: factor = 18'h0497b;
      5'h07: factor = 18'h04b32;
      5'h08: factor = 18'h04cf2;
      5'h09: factor = 18'h04ebd;
      5'h0a: factor = 18'h05092;
      5'h0b: factor = 18'h05273;
      5'h0c: factor = 18'h0545e;
      5'h0d: factor = 18'h05655;
      5'h0e: factor = 18'h05858;
      5'h0f: factor = 18'h05a67;
      5'h10: factor = 18'h05c82;
      5'h11: factor = 18'h05eaa;
      5'h12: factor = 18'h060de;
      5'h13: factor = 18'h06320;
      5'h14: factor = 18'h0656f;
      5'h15: factor = 18'h067cc;
      5'h16: factor = 18'h06a37;
      5'h17: factor = 18'h06cb0;
      5'h18: factor = 18'h06f38;
      5'h19: factor = 18'h071cf;
      5'h1a: factor = 18'h07476;
      5'h1b: factor = 18'h0772c;
      5'h1c: factor = 18'h079f3;
      5'h1d: factor = 18'h07cca;
      5'h1e: factor = 18'h07fb2;
      5'h1f: factor = 18'h082ac;
      default: factor = 18'h04000;
    endcase
  end

endmodule // cdgo_gain_lut

// file: logic/cdgo_lane.sv
// One lane of the correction datapath: offset add, gain, saturation.
// Assumes samples are signed 14-bit words arriving with a valid strobe.
`timescale 1ns/1ns
`include "cdgo_regs.svh"
module cdgo_lane
  import cdgo_pkg::*;
#(
  parameter int SAMPLE_W = 14
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic srst,
  // Settings.
  input wire cdgo_gain_t gain_code,
  input wire cdgo_ofs_t dc_shift,
  input wire logic amplify_correction_enable,
  input wire logic dc_shift_correction_enable,
  // Samples.
  input wire logic in_valid,
  input wire logic signed [SAMPLE_W-1:0] in_sample,
  output logic out_valid,
  output logic signed [SAMPLE_W-1:0] out_sample
);

  localparam int SUM_W = SAMPLE_W + 1;
  localparam int PROD_W = SUM_W + 19;
  localparam logic signed [PROD_W-1:0] MAX_V = PROD_W'(2 ** (SAMPLE_W - 1) - 1);
  localparam logic signed [PROD_W-1:0] MIN_V = -PROD_W'(2 ** (SAMPLE_W - 1));

  logic [17:0] factor;
  logic signed [SUM_W-1:0] shifted;
  logic signed [PROD_W-1:0] scaled;
  logic signed [PROD_W-1:0] next_scaled;

  cdgo_gain_lut u_lut (
    .code(gain_code),
    .factor(factor)
  );

  // -------------------------------------------------------------------------
  // Offset is sign-extended so one unit is one sample LSB.
  // -------------------------------------------------------------------------
  always_comb begin
    shifted = SUM_W'(in_sample); // R5
    if (dc_shift_correction_enable) begin
      shifted = SUM_W'(in_sample) + SUM_W'(dc_shift); // R3 R4 R5
    end
  end

  // Gain as a Q2.14 multiply; code is ignored while gain is off.
  always_comb begin
    next_scaled = PROD_W'(shifted);
    if (amplify_correction_enable) begin
      next_scaled = (PROD_W'(shifted) * $signed({1'b0, factor})) >>> `CDGO_GAIN_FRAC; // R1 R2
    end
  end

  // Saturate rather than wrap, since a wrap flips the echo polarity.
  always_comb begin
    scaled = next_scaled;
    if (next_scaled > MAX_V) begin
      scaled = MAX_V; // R11
    end else if (next_scaled < MIN_V) begin
      scaled = MIN_V; // R11
    end
  end

  // One register stage for the corrected sample.
  always_ff @(posedge mclk) begin
    if (srst) begin
      out_valid <= 1'b0;
      out_sample <= '0;
    end else begin
      out_valid <= in_valid;
      out_sample <= scaled[SAMPLE_W-1:0]; // R11
    end
  end

endmodule // cdgo_lane

// file: logic/cdgo_top.sv
// Register bank and three correction lanes for digital gain and offset.
// Assumes a one-cycle register port and samples synchronous to mclk.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ns
`include "cdgo_regs.svh"
module cdgo_top
  import cdgo_pkg::*;
#(
  parameter int SAMPLE_W = 14,
  parameter int LANES = 3
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic srst,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Sample stream, lanes packed lane 1 lowest.
  input wire logic samp_valid,
  input wire logic [LANES*SAMPLE_W-1:0] samp_in,
  output logic corr_valid,
  output logic [LANES*SAMPLE_W-1:0] corr_out,
  // Current mode.
  output cdgo_mode_e mode
);

  // -------------------------------------------------------------------------
  // Storage: each lane has a gain-and-shift word and an offset mirror word.
  // -------------------------------------------------------------------------
  cdgo_word_t gain_word [LANES];
  cdgo_word_t mirror_word [LANES];
  logic amplify_correction_enable;
  logic dc_shift_correction_enable;
  logic [LANES-1:0] lane_valid;
  logic [LANES*SAMPLE_W-1:0] lane_out;

  // Index of the lane whose gain word sits at the address, or LANES.
  function automatic int gain_slot(input logic [7:0] a);
    int i;
    gain_slot = LANES;
    for (i = 0; i < LANES; i++) begin
      if (a == 8'(`CDGO_CH1_GAIN_AND_SHIFT + 2 * i)) begin
        gain_slot = i; // R7 R10
      end
    end
  endfunction

  // Index of the lane whose mirror word sits at the address, or LANES.
  function automatic int mirror_slot(input logic [7:0] a);
    int i;
    mirror_slot = LANES;
    for (i = 0; i < LANES; i++) begin
      if (a == 8'(`CDGO_CH1_OFFSET_MIRROR + 2 * i)) begin
        mirror_slot = i; // R7 R8
      end
    end
  endfunction

  // -------------------------------------------------------------------------
  // Register writes: lane words store every bit as written, control keeps bits 1..0; zero after reset.
  // -------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int i = 0; i < LANES; i++) begin
        gain_word[i] <= `CDGO_REG_RESET; // R9
        mirror_word[i] <= `CDGO_REG_RESET; // R9
      end
    end else if (reg_wr) begin
      for (int i = 0; i < LANES; i++) begin
        if (gain_slot(reg_addr) == i) begin
          gain_word[i] <= reg_wdata; // R9 R10
        end
        if (mirror_slot(reg_addr) == i) begin
          mirror_word[i] <= reg_wdata; // R8 R9
        end
      end
    end
  end

  // Global enables live in a control register of their own.
  always_ff @(posedge mclk) begin
    if (srst) begin
      amplify_correction_enable <= 1'b0;
      dc_shift_correction_enable <= 1'b0;
    end else if (reg_wr && reg_addr == `CDGO_CTRL) begin
      amplify_correction_enable <= reg_wdata[`CDGO_CTRL_GAIN_EN_BIT];
      dc_shift_correction_enable <= reg_wdata[`CDGO_CTRL_OFS_EN_BIT];
    end
  end

  // -------------------------------------------------------------------------
  // Read data stands only in the cycle after the strobe; unmapped reads zero.
  // -------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= '0;
      if (reg_addr == `CDGO_CTRL) begin
        reg_rdata <= {14'h0000, dc_shift_correction_enable, amplify_correction_enable};
      end
      for (int i = 0; i < LANES; i++) begin
        if (gain_slot(reg_addr) == i) begin
          reg_rdata <= gain_word[i]; // R9
        end
        if (mirror_slot(reg_addr) == i) begin
          reg_rdata <= mirror_word[i]; // R9
        end
      end
    end else begin
      reg_rdata <= '0;
    end
  end

  // Mode reflects which corrections are live.
  always_ff @(posedge mclk) begin
    if (srst) begin
      mode <= cdgo_pass;
    end else begin
      case ({dc_shift_correction_enable, amplify_correction_enable})
        2'b01: mode <= cdgo_gain_only;
        2'b10: mode <= cdgo_ofs_only;
        2'b11: mode <= cdgo_both;
        default: mode <= cdgo_pass;
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // Lanes. The datapath takes the offset from the gain-and-shift word only;
  // the mirror copy is expected to match and is kept for readback.
  // -------------------------------------------------------------------------
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    cdgo_lane #(
      .SAMPLE_W(SAMPLE_W)
    ) u_lane (
      .mclk(mclk),
      .srst(srst),
      .gain_code(gain_word[g][`CDGO_GAIN_MSB:`CDGO_GAIN_LSB]), // R2
      .dc_shift(gain_word[g][`CDGO_OFS_MSB:`CDGO_OFS_LSB]), // R4 R6
      .amplify_correction_enable(amplify_correction_enable), // R1
      .dc_shift_correction_enable(dc_shift_correction_enable), // R3
      .in_valid(samp_valid),
      .in_sample(samp_in[g*SAMPLE_W +: SAMPLE_W]),
      .out_valid(lane_valid[g]),
      .out_sample(lane_out[g*SAMPLE_W +: SAMPLE_W])
    );
  end

  // Outputs are already registered inside the lanes.
  assign corr_valid = lane_valid[0];
  assign corr_out = lane_out;

endmodule // cdgo_top

// file: bench/cdgo_top_assertions.sv
// Port-level checker for the gain and offset correction block.
// Assumes it is bound into cdgo_top and sees only that module's ports.
`timescale 1ns/1ns
`include "cdgo_regs.svh"
module cdgo_top_assertions
  import cdgo_pkg::*;
#(
  parameter int SAMPLE_W = 14,
  parameter int LANES = 3
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic srst,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Samples and mode.
  input wire logic samp_valid,
  input wire logic [LANES*SAMPLE_W-1:0] samp_in,
  input wire logic corr_valid,
  input wire logic [LANES*SAMPLE_W-1:0] corr_out,
  input wire cdgo_mode_e mode
);
  // --------------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------------
  // Only the six lane words read back as written; the control word is judged through mode.
  wire logic mapped = reg_addr inside {[8'h0d:8'h12]};

  a_reset_clears: assert property (@(posedge mclk) srst |=>
    !corr_valid && reg_rdata == 16'h0 && mode == cdgo_pass) else $error("reset left outputs set");
  a_rdata_idle: assert property (@(posedge mclk) disable iff (srst)
    !$past(reg_rd) |-> reg_rdata == 16'h0) else $error("read data outside read slot");
  a_unmapped_zero: assert property (@(posedge mclk) disable iff (srst)
    reg_rd && !mapped && reg_addr != `CDGO_CTRL |=> reg_rdata == 16'h0) else $error("hole read");
  a_write_readback: assert property (@(posedge mclk) disable iff (srst)
    reg_wr && mapped ##1 reg_rd && $stable(reg_addr) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("read after write mismatch");
  a_ctrl_mode: assert property (@(posedge mclk) disable iff (srst)
    reg_wr && reg_addr == `CDGO_CTRL |-> ##2 mode == cdgo_mode_e'($past(reg_wdata[1:0], 2)))
    else $error("mode does not follow enables");
  a_valid_rise: assert property (@(posedge mclk) disable iff (srst)
    $past(samp_valid) && !$past(srst) |-> corr_valid) else $error("sample lost");
  a_valid_fall: assert property (@(posedge mclk) disable iff (srst)
    !$past(samp_valid) |-> !corr_valid) else $error("spurious output");
  a_pass_through: assert property (@(posedge mclk) disable iff (srst)
    corr_valid && mode == cdgo_pass |-> corr_out == $past(samp_in)) else $error("pass altered");

  c_both: cover property (@(posedge mclk) corr_valid && mode == cdgo_both);
  c_gain: cover property (@(posedge mclk) corr_valid && mode == cdgo_gain_only);
  c_ofs: cover property (@(posedge mclk) corr_valid && mode == cdgo_ofs_only);
endmodule // cdgo_top_assertions

bind cdgo_top cdgo_top_assertions #(.SAMPLE_W(SAMPLE_W), .LANES(LANES)) i_chk (.mclk, .srst,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .samp_valid, .samp_in, .corr_valid,
  .corr_out, .mode);

// file: bench/cdgo_top_tb.sv
// Self-checking bench for the gain and offset correction block.
// Assumes the design files and the port checker are compiled before it.
`timescale 1ns/1ns
`include "cdgo_regs.svh"
`define CHK(what, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("FAIL %s expected %h seen %h", what, e, g); end end
module cdgo_top_tb
  import cdgo_pkg::*;
;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic samp_valid = 1'b0;
  logic [41:0] samp_in = 42'h0;
  logic [15:0] reg_rdata;
  logic corr_valid;
  logic [41:0] corr_out;
  cdgo_mode_e mode;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;

  cdgo_top #(.SAMPLE_W(14), .LANES(3)) i_dut (.mclk, .srst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .samp_valid, .samp_in, .corr_valid, .corr_out, .mode);

  // --------------------------------------------------------------------------
  // Drivers and reference
  // --------------------------------------------------------------------------
  // Clock at 50 MHz.
  always #10 mclk = ~mclk;

  // Read one word; the strobe also ends any write started just before.
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 `CHK("rdata", e, reg_rdata)
  endtask

  // Write then read back at once, the tightest order the port allows.
  task automatic wrrd(input logic [7:0] a, input logic [15:0] d, input logic [15:0] e);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    rd(a, e);
  endtask

  // Reference: offset, then gain, then one saturation to the 14-bit range.
  function automatic logic [13:0] lane_expect(int x, int o, int n, logic [1:0] en);
    int s;
    s = x;
    if (en[1]) s += o;
    if (en[0]) s = (s * $rtoi(16384.0 * (10.0 ** (n * 0.01)) + 0.5)) >>> 14;
    if (s > 8191) s = 8191;
    if (s < -8192) s = -8192;
    return s[13:0];
  endfunction

  // Program all lanes and the enables, push one sample, judge every lane.
  task automatic lanes(input logic [1:0] en, input int n[3], input int o[3], input int x[3]);
    logic [15:0] w;
    wrrd(`CDGO_CTRL, {14'h0, en}, {14'h0, en});
    for (int i = 0; i < 3; i++) begin
      w = {5'(n[i]), 1'b0, 10'(o[i])};
      wrrd(8'(8'h0d + 2 * i), w, w);
      wrrd(8'(8'h0e + 2 * i), {6'h0, w[9:0]}, {6'h0, w[9:0]});
    end
    @(posedge mclk);
    samp_valid <= 1'b1;
    for (int i = 0; i < 3; i++) samp_in[14*i +: 14] <= 14'(x[i]);
    @(posedge mclk);
    samp_valid <= 1'b0;
    #1 `CHK("valid", 1'b1, corr_valid)
    `CHK("mode", en, mode)
    for (int i = 0; i < 3; i++) `CHK("lane", lane_expect(x[i], o[i], n[i], en),
      corr_out[14*i +: 14])
  endtask

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_reset;
    for (int a = 'h0d; a <= 'h12; a++) rd(8'(a), 16'h0);
    rd(`CDGO_CTRL, 16'h0);
  endtask

  // Every bit of every word, then holes either side and an ignored write.
  task automatic t_regs;
    for (int a = 'h0d; a <= 'h12; a++) wrrd(8'(a), 16'hffff ^ 16'(a), 16'hffff ^ 16'(a));
    wrrd(8'h13, 16'hffff, 16'h0);
    rd(8'h0c, 16'h0);
    rd(8'h0e, 16'hfff1);
  endtask

  task automatic t_pass;
    lanes(2'b00, '{30, 30, 30}, '{511, -512, -1}, '{-8192, 8191, 123});
  endtask

  task automatic t_ofs;
    lanes(2'b10, '{31, 5, 0}, '{-512, 511, -1}, '{-8000, 100, 0});
  endtask

  task automatic t_gain;
    lanes(2'b01, '{0, 30, 31}, '{-7, 300, 9}, '{1000, -4000, 8000});
  endtask

  task automatic t_both;
    lanes(2'b11, '{10, 1, 31}, '{100, -300, 511}, '{-3000, 8191, -8192});
  endtask

  task automatic conclude;
    if (miscompares == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // A hang is cut short well after the 136 or so cycles the run needs.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 4000) begin
      miscompares++;
      conclude();
    end
  end

  initial begin
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    t_reset();
    t_regs();
    t_pass();
    t_ofs();
    t_gain();
    t_both();
    conclude();
  end
endmodule // cdgo_top_tb
